// file: verilog/sepr_top.v
`timescale 1ns/1ps
`include "sepr_regs.vh"
module sepr_top #(
    parameter AW          = 11,
    parameter FIFO_DEPTH  = 16,
    parameter WAFER_PART  = 0
) (
    input  wire       clk_sys,
    input  wire       sys_rst,
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    input  wire       write_protect_input,
    output reg        selected,
    output reg [10:0] addr_counter
);
    localparam ST_IDLE = 3'd0;
    localparam ST_SEL  = 3'd1;
    localparam ST_ADR  = 3'd2;
    localparam ST_SEND = 3'd3;
    localparam ST_MACK = 3'd4;
    localparam ST_SACK = 3'd5;
    localparam ST_WAIT = 3'd6;

    localparam DEPTH = 1 << AW;

    reg [7:0]    mem [0:DEPTH-1];
    reg [1:0]    scl_sync;
    reg [1:0]    sda_sync;
    reg          scl_q;
    reg          sda_q;
    reg [2:0]    state;
    reg [2:0]    ack_next;
    reg [3:0]    bit_cnt;
    reg [7:0]    shift;
    reg [7:0]    tx_byte;
    reg          tx_loaded;
    reg          fetch_pend;
    reg [10:0]   fetch_addr;
    wire         scl_rise;
    wire         scl_fall;
    wire         start_cond;
    wire         stop_cond;
    wire [7:0]   fifo_data;
    wire         fifo_valid;
    wire         fifo_in_ready;
    wire         fifo_take;
    wire         fifo_flush;
    integer      i;

    function [7:0] sepr_init;
        input integer idx;
        begin
            if (WAFER_PART != 0 && idx == DEPTH - 1) begin
                sepr_init = `SEPR_WAFER_MK;
            end else begin
                sepr_init = `SEPR_ERASED;
            end
        end
    endfunction

    function [10:0] sepr_inc;
        input [10:0] a;
        begin
            if (a == `SEPR_ADDR_TOP) begin
                sepr_inc = `SEPR_ADDR_ZERO;
            end else begin
                sepr_inc = a + 11'h001;
            end
        end
    endfunction

    initial begin
        for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] = sepr_init(i);
        end
    end

    assign scl_rise   = scl_sync[1] && !scl_q;
    assign scl_fall   = !scl_sync[1] && scl_q;
    assign start_cond = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
    assign stop_cond  = scl_sync[1] && scl_q && !sda_q && sda_sync[1];
    assign fifo_flush = (state != ST_SEND) && (state != ST_MACK)
                        && (state != ST_WAIT) && (state != ST_SACK);
    assign fifo_take  = (state == ST_WAIT) && fifo_valid && !scl_sync[1];

    // Read-ahead prefetches upcoming bytes so the next byte is ready.
    sepr_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (4)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .flush     (fifo_flush),
        .in_data   (mem[fetch_addr[AW-1:0]]),
        .in_valid  (fetch_pend),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_take)
    );

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            scl_sync <= 2'b11;
            sda_sync <= 2'b11;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_q    <= scl_sync[1];
            sda_q    <= sda_sync[1];
        end
    end

    // Write-protect level is deliberately not looked at by this path.
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state        <= ST_IDLE;
            ack_next     <= ST_IDLE;
            bit_cnt      <= 4'h0;
            shift        <= 8'h00;
            tx_byte      <= 8'hFF;
            tx_loaded    <= 1'b0;
            fetch_pend   <= 1'b0;
            fetch_addr   <= 11'h000;
            sda_out      <= 1'b0;
            sda_oe       <= 1'b0;
            selected     <= 1'b0;
            addr_counter <= 11'h000;
        end else if (stop_cond) begin
            state    <= ST_IDLE;
            sda_oe   <= 1'b0;
            selected <= 1'b0;
        end else if (start_cond) begin
            state   <= ST_SEL;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
        end else begin
            if (fetch_pend && fifo_in_ready) begin
                fetch_addr <= sepr_inc(fetch_addr);
            end
            if (fifo_flush) begin
                fetch_pend <= 1'b0;
            end
            case (state)
            ST_IDLE: begin
                sda_oe <= 1'b0;
            end
            ST_SEL, ST_ADR: begin
                if (scl_rise) begin
                    shift   <= {shift[6:0], sda_sync[1]};
                    bit_cnt <= bit_cnt + 4'h1;
                end
                if (scl_fall && bit_cnt == 4'h8) begin
                    bit_cnt <= 4'h0;
                    if (state == ST_ADR) begin
                        addr_counter <= {addr_counter[10:8], shift};
                        sda_out  <= 1'b0;
                        sda_oe   <= 1'b1;
                        // Data bytes of a write are not taken or acknowledged.
                        ack_next <= ST_IDLE;
                        state    <= ST_SACK;
                    end else if (shift[7:4] == `SEPR_TYPE_ID) begin
                        selected <= 1'b1;
                        sda_out  <= 1'b0;
                        sda_oe   <= 1'b1;
                        state    <= ST_SACK;
                        if (shift[`SEPR_DIR_BIT]) begin
                            ack_next   <= ST_WAIT;
                            fetch_addr <= addr_counter;
                            fetch_pend <= 1'b1;
                        end else begin
                            addr_counter[10:8] <= shift[3:1];
                            ack_next <= ST_ADR;
                        end
                    end else begin
                        state    <= ST_IDLE;
                        selected <= 1'b0;
                    end
                end
            end
            ST_SACK: begin
                if (scl_fall) begin
                    sda_oe  <= 1'b0;
                    bit_cnt <= 4'h0;
                    state   <= ack_next;
                end
            end
            ST_WAIT: begin
                if (fifo_take) begin
                    tx_byte <= {fifo_data[6:0], 1'b1};
                    sda_out <= fifo_data[7];
                    sda_oe  <= 1'b1;
                    bit_cnt <= 4'h1;
                    state   <= ST_SEND;
                end
            end
            ST_SEND: begin
                if (scl_fall) begin
                    if (bit_cnt == 4'h8) begin
                        sda_oe <= 1'b0;
                        state  <= ST_MACK;
                        addr_counter <= sepr_inc(addr_counter);
                    end else begin
                        sda_out <= tx_byte[7];
                        tx_byte <= {tx_byte[6:0], 1'b1};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
            end
            ST_MACK: begin
                if (scl_rise) begin
                    tx_loaded <= !sda_sync[1];
                end
                if (scl_fall) begin
                    if (tx_loaded) begin
                        state <= ST_WAIT;
                    end else begin
                        state    <= ST_IDLE;
                        selected <= 1'b0;
                    end
                end
            end
            default: begin
                state <= ST_IDLE;
            end
            endcase
        end
    end
endmodule

// file: verilog/sepr_regs.vh
`ifndef SEPR_REGS_VH
`define SEPR_REGS_VH
`define SEPR_TYPE_ID   4'hA
`define SEPR_ERASED    8'hFF
`define SEPR_WAFER_MK  8'h22
`define SEPR_ADDR_TOP  11'h7FF
`define SEPR_ADDR_ZERO 11'h000
`define SEPR_DIR_BIT   0
`endif

// file: verilog/sepr_fifo.v
`timescale 1ns/1ps
module sepr_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_sys,
    input  wire             sys_rst,
    input  wire             flush,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            do_wr;
    wire            do_rd;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    always @(posedge clk_sys) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst || flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// file: tb/sepr_top_monitor.sv
`timescale 1ns/1ps
module sepr_top_monitor (
    input wire        clk_sys,
    input wire        sys_rst,
    input wire        scl_in,
    input wire        sda_in,
    input wire        sda_out,
    input wire        sda_oe,
    input wire        write_protect_input,
    input wire        selected,
    input wire [10:0] addr_counter
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    a_idle_quiet: assert property (
        !selected && !$past(selected) |-> !sda_oe) else $error("idle drive");
    a_deselect_quiet: assert property (
        $fell(selected) |-> !sda_oe [*8]) else $error("drive after end");
    a_scl_high_hold: assert property (
        scl_in && $past(scl_in) && $past(scl_in, 2)
        |-> $stable({sda_oe, sda_out})) else $error("change in high");
    a_drive_scl_low: assert property (
        $rose(sda_oe) |-> !$past(scl_in, 2)) else $error("late drive");
    a_step_one: assert property (
        $changed(addr_counter) && ($past(sda_oe) || $past(sda_oe, 2))
        |-> addr_counter == $past(addr_counter) + 11'h001)
        else $error("bad step");
    a_wrap_zero: assert property (
        $changed(addr_counter) && $past(addr_counter) == 11'h7FF
        && $past(sda_oe) |-> addr_counter == 11'h000) else $error("no wrap");
    a_idle_count: assert property (
        !selected && !$past(selected) |-> $stable(addr_counter))
        else $error("idle count");
    a_ninth_release: assert property (
        $changed(addr_counter) && $past(sda_oe) |-> ##[0:2] !sda_oe [*5])
        else $error("no release");
endmodule

bind sepr_top sepr_top_monitor u_mon (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .write_protect_input(write_protect_input), .selected(selected),
    .addr_counter(addr_counter)
);

// file: tb/sepr_master.sv
`timescale 1ns/1ps
module sepr_master (
    input  wire  clk_sys,
    input  wire  sda_out,
    input  wire  sda_oe,
    output logic scl,
    output wire  sda
);
    logic sdm = 1'b1;
    initial scl = 1'b1;
    // Open-drain line with a pull-up: low if either side pulls low.
    assign sda = sdm & ~(sda_oe & ~sda_out);
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task start;
        sdm <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sdm <= 1'b0;
        tick(4);
        scl <= 1'b0;
        tick(2);
    endtask
    task stop;
        sdm <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sdm <= 1'b1;
        tick(4);
    endtask
    task bit_io(input logic b, output logic r);
        sdm <= b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        @(negedge clk_sys);
        r = sda;
        tick(2);
        scl <= 1'b0;
        tick(2);
    endtask
    task send(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task recv(input logic ack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            v[i] = r;
        end
        bit_io(~ack, r);
    endtask
endmodule

// file: tb/test_sepr_top.sv
`timescale 1ns/1ps
module test_sepr_top;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        wp = 1'b0;
    wire         scl;
    wire         sda;
    wire         sda_out;
    wire         sda_oe;
    wire         selected;
    wire  [10:0] addr_counter;
    int          fails = 0;
    int          checks_done = 0;
    initial forever #5 clk_sys = ~clk_sys;
    sepr_top #(.WAFER_PART(1)) DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .write_protect_input(wp),
        .selected(selected), .addr_counter(addr_counter)
    );
    sepr_master M (
        .clk_sys(clk_sys), .sda_out(sda_out), .sda_oe(sda_oe),
        .scl(scl), .sda(sda)
    );
    task chk(input logic [10:0] seen, input logic [10:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task t_random;
        logic       a;
        logic [7:0] d;
        wp <= 1'b1;
        M.start();
        M.send(8'hAE, a);
        chk(a, 1'b1);
        M.send(8'hFE, a);
        chk(a, 1'b1);
        chk(addr_counter, 11'h7FE);
        M.start();
        M.send(8'hAF, a);
        chk(a, 1'b1);
        M.recv(1'b1, d);
        chk(d, 8'hFF);
        M.recv(1'b1, d);
        chk(d, 8'h22);
        M.recv(1'b0, d);
        chk(d, 8'hFF);
        M.tick(2);
        chk(selected, 1'b0);
        M.stop();
        chk(addr_counter, 11'h001);
        chk(selected, 1'b0);
        $display("random read test done");
    endtask
    task t_current;
        logic       a;
        logic [7:0] d;
        wp <= 1'b0;
        M.start();
        M.send(8'hA1, a);
        chk(a, 1'b1);
        M.recv(1'b1, d);
        chk(d, 8'hFF);
        chk(addr_counter, 11'h002);
        M.recv(1'b0, d);
        chk(d, 8'hFF);
        M.tick(2);
        chk(selected, 1'b0);
        M.stop();
        chk(addr_counter, 11'h003);
        chk(selected, 1'b0);
        $display("current read test done");
    endtask
    task t_mismatch;
        logic a;
        M.start();
        M.send(8'hB1, a);
        chk(a, 1'b0);
        chk(selected, 1'b0);
        M.stop();
        chk(addr_counter, 11'h003);
        M.start();
        M.send(8'hA0, a);
        chk(a, 1'b1);
        chk(selected, 1'b1);
        M.start();
        M.send(8'hB1, a);
        chk(a, 1'b0);
        chk(selected, 1'b0);
        M.stop();
        chk(addr_counter, 11'h003);
        $display("mismatch test done");
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        t_random();
        t_current();
        t_mismatch();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        give_verdict();
    end
endmodule
